// ==== rtl/ec_bus_matrix_router.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ec_bus_matrix_regs.vh"

// Behaviour
// RQ1 - One flat 32-bit byte address space
// RQ2 - Little-endian lanes always, no big-endian
// RQ3 - Decoder steers to three ports or peripheral
// RQ4 - Closely-coupled fetches go to instruction port
// RQ5 - Closely-coupled data goes to data port
// RQ6 - Other on-chip addresses use system port
// RQ7 - Bit-band aliases always use system port
// RQ8 - Peripheral bus accepts only word transfers
// RQ9 - One buffered write; next write waits
// RQ10 - Debug master reaches all memory independently
// RQ11 - Memory side serialises same-block code/data
// RQ12 - Reset returns all routing state
// RQ13 - Runs synchronously on free-running clock
module ec_bus_matrix_router
(
    input wire i_clk,
    input wire i_nrst,
    input wire i_fetch_req,
    input wire [31:0] i_fetch_addr,
    input wire i_data_req,
    input wire i_data_write,
    input wire [1:0] i_data_size,
    input wire [31:0] i_data_addr,
    input wire [31:0] i_data_wdata,
    input wire i_dbg_req,
    input wire i_dbg_write,
    input wire [1:0] i_dbg_size,
    input wire [31:0] i_dbg_addr,
    input wire [31:0] i_dbg_wdata,
    output wire o_fetch_ack,
    output wire o_data_ack,
    output wire o_dbg_ack,
    output wire o_resp_err,
    output wire [31:0] o_resp_rdata,
    output wire o_instr_req,
    input wire i_instr_ack,
    input wire [31:0] i_instr_rdata,
    output wire o_data_port_req,
    input wire i_data_port_ack,
    input wire [31:0] i_data_port_rdata,
    output wire o_sys_req,
    input wire i_sys_ack,
    input wire [31:0] i_sys_rdata,
    output wire o_ppb_psel,
    output wire o_ppb_penable,
    input wire i_ppb_pready,
    input wire [31:0] i_ppb_prdata,
    output wire [31:0] o_mem_addr,
    output wire o_mem_write,
    output wire [1:0] o_mem_size,
    output wire [3:0] o_mem_strb,
    output wire [31:0] o_mem_wdata
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_APB_SETUP = 2'h2;
    localparam [1:0] ST_APB_ACCESS = 2'h3;

    // Address decode; one map for every master
    function [1:0] decode;
        input [31:0] addr;
        input fetch;
        begin
            if (addr[`BB_HI] == `BB_SRAM_TAG || addr[`BB_HI] == `BB_PERI_TAG)
                decode = `TGT_SYS; // RQ7
            else if (addr[`PPB_HI] == `PPB_TAG)
                decode = `TGT_PPB; // RQ3
            else if (addr[`CCM_HI] == `CCM_TAG)
                decode = fetch ? `TGT_INSTR : `TGT_DATA; // RQ4 RQ5
            else
                decode = `TGT_SYS; // RQ6
        end
    endfunction

    // Byte lanes selected by low address bits
    function [3:0] strobe;
        input [1:0] size;
        input [1:0] off;
        begin
            case (size)
                `SZ_BYTE: strobe = `STRB_BYTE << off;
                `SZ_HALF: strobe = `STRB_HALF << {off[1], 1'b0};
                default: strobe = `STRB_WORD;
            endcase
        end
    endfunction

    // Right-aligned write data copied into every lane
    function [31:0] place;
        input [31:0] wdata;
        input [1:0] size;
        begin
            case (size)
                `SZ_BYTE: place = {4{wdata[7:0]}};
                `SZ_HALF: place = {2{wdata[15:0]}};
                default: place = wdata;
            endcase
        end
    endfunction

    // Lane to right-aligned read data, lowest byte first
    function [31:0] extract;
        input [31:0] rdata;
        input [1:0] size;
        input [1:0] off;
        reg [31:0] shifted;
        begin
            shifted = rdata >> {off, 3'b000};
            case (size)
                `SZ_BYTE: extract = {24'h00_0000, shifted[7:0]};
                `SZ_HALF: extract = {16'h0000, shifted[15:0]};
                default: extract = rdata;
            endcase
        end
    endfunction

    reg [1:0] state_reg;
    reg [1:0] src_reg;
    reg [1:0] tgt_reg;
    reg dbg_turn_reg;
    reg fetch_ack_reg;
    reg data_ack_reg;
    reg dbg_ack_reg;
    reg err_reg;
    reg [31:0] rdata_reg;
    reg instr_req_reg;
    reg data_port_req_reg;
    reg sys_req_reg;
    reg psel_reg;
    reg penable_reg;
    reg [31:0] addr_reg;
    reg write_reg;
    reg [1:0] size_reg;
    reg [3:0] strb_reg;
    reg [31:0] wdata_reg;

    wire wb_full;
    wire [31:0] wb_addr;
    wire [1:0] wb_size;
    wire [31:0] wb_wdata;

    reg start;
    reg push;
    reg [1:0] sel_src;
    reg [31:0] sel_addr;
    reg sel_write;
    reg [1:0] sel_size;
    reg [31:0] sel_wdata;
    reg [1:0] sel_tgt;
    reg sel_err;
    reg [31:0] done_rdata;
    reg done;

    // Masters still seeing their ack are not taken again
    wire fetch_live = i_fetch_req && !fetch_ack_reg;
    wire data_live = i_data_req && !data_ack_reg;
    wire dbg_live = i_dbg_req && !dbg_ack_reg;
    wire dbg_first = dbg_live && (dbg_turn_reg || !data_live);

    // Pick the next access; a full write buffer drains first
    always @*
    begin
        start = 1'b0;
        push = 1'b0;
        sel_src = `SRC_FETCH;
        sel_addr = i_fetch_addr;
        sel_write = 1'b0;
        sel_size = `SZ_WORD;
        sel_wdata = 32'h0000_0000;
        if (state_reg == ST_IDLE)
        begin
            if (wb_full)
            begin
                start = 1'b1; // RQ9
                sel_src = `SRC_WBUF;
                sel_addr = wb_addr;
                sel_write = 1'b1;
                sel_size = wb_size;
                sel_wdata = wb_wdata;
            end
            else if (dbg_first)
            begin
                start = 1'b1; // RQ10
                sel_src = `SRC_DBG;
                sel_addr = i_dbg_addr;
                sel_write = i_dbg_write;
                sel_size = i_dbg_size;
                sel_wdata = i_dbg_wdata;
            end
            else if (data_live)
            begin
                start = 1'b1;
                sel_src = `SRC_DATA;
                sel_addr = i_data_addr;
                sel_write = i_data_write;
                sel_size = i_data_size;
                sel_wdata = i_data_wdata;
            end
            else if (fetch_live)
            begin
                start = 1'b1;
            end
        end
        sel_tgt = decode(sel_addr, sel_src == `SRC_FETCH); // RQ1
        // Narrow peripheral access, or fetch from it, is refused
        sel_err = sel_tgt == `TGT_PPB && (sel_size != `SZ_WORD || sel_src == `SRC_FETCH); // RQ8
        // Core data writes retire into the buffer at once
        if (start && sel_src == `SRC_DATA && sel_write && !sel_err)
            push = 1'b1; // RQ9
    end

    // Completion of the access in flight
    always @*
    begin
        done = 1'b0;
        done_rdata = 32'h0000_0000;
        if (state_reg == ST_WAIT)
        begin
            case (tgt_reg)
                `TGT_INSTR:
                begin
                    done = i_instr_ack;
                    done_rdata = i_instr_rdata;
                end
                `TGT_DATA:
                begin
                    done = i_data_port_ack;
                    done_rdata = i_data_port_rdata;
                end
                default:
                begin
                    done = i_sys_ack;
                    done_rdata = i_sys_rdata;
                end
            endcase
        end
        else if (state_reg == ST_APB_ACCESS)
        begin
            done = i_ppb_pready;
            done_rdata = i_ppb_prdata;
        end
    end

    ec_write_buffer u_wbuf
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_push(push),
        .i_addr(i_data_addr),
        .i_size(i_data_size),
        .i_wdata(i_data_wdata),
        .i_pop(done && src_reg == `SRC_WBUF),
        .o_full(wb_full),
        .o_addr(wb_addr),
        .o_size(wb_size),
        .o_wdata(wb_wdata)
    );

    // Routing state machine, one access in flight
    always @(posedge i_clk) // RQ13
    begin
        if (!i_nrst)
        begin
            state_reg <= ST_IDLE; // RQ12
            src_reg <= `SRC_FETCH;
            tgt_reg <= `TGT_SYS;
            dbg_turn_reg <= 1'b0;
            fetch_ack_reg <= 1'b0;
            data_ack_reg <= 1'b0;
            dbg_ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            instr_req_reg <= 1'b0;
            data_port_req_reg <= 1'b0;
            sys_req_reg <= 1'b0;
            psel_reg <= 1'b0;
            penable_reg <= 1'b0;
            addr_reg <= 32'h0000_0000;
            write_reg <= 1'b0;
            size_reg <= `SZ_WORD;
            strb_reg <= 4'h0;
            wdata_reg <= 32'h0000_0000;
        end
        else
        begin
            fetch_ack_reg <= 1'b0;
            data_ack_reg <= 1'b0;
            dbg_ack_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        // Debug and core data alternate so neither starves
                        if (sel_src == `SRC_DBG || sel_src == `SRC_DATA)
                            dbg_turn_reg <= sel_src == `SRC_DATA;
                        err_reg <= sel_err;
                        if (sel_err || push)
                        begin
                            data_ack_reg <= sel_src == `SRC_DATA;
                            dbg_ack_reg <= sel_src == `SRC_DBG;
                            fetch_ack_reg <= sel_src == `SRC_FETCH;
                        end
                        else
                        begin
                            src_reg <= sel_src;
                            tgt_reg <= sel_tgt;
                            addr_reg <= sel_addr;
                            write_reg <= sel_write;
                            size_reg <= sel_size;
                            strb_reg <= strobe(sel_size, sel_addr[1:0]); // RQ2
                            wdata_reg <= place(sel_wdata, sel_size); // RQ2
                            instr_req_reg <= sel_tgt == `TGT_INSTR;
                            data_port_req_reg <= sel_tgt == `TGT_DATA;
                            sys_req_reg <= sel_tgt == `TGT_SYS;
                            psel_reg <= sel_tgt == `TGT_PPB;
                            state_reg <= (sel_tgt == `TGT_PPB) ? ST_APB_SETUP : ST_WAIT;
                        end
                    end
                end
                ST_APB_SETUP:
                begin
                    penable_reg <= 1'b1; // RQ8
                    state_reg <= ST_APB_ACCESS;
                end
                ST_WAIT, ST_APB_ACCESS:
                begin
                    if (done)
                    begin
                        instr_req_reg <= 1'b0;
                        data_port_req_reg <= 1'b0;
                        sys_req_reg <= 1'b0;
                        psel_reg <= 1'b0;
                        penable_reg <= 1'b0;
                        rdata_reg <= extract(done_rdata, size_reg, addr_reg[1:0]); // RQ2
                        fetch_ack_reg <= src_reg == `SRC_FETCH;
                        data_ack_reg <= src_reg == `SRC_DATA;
                        dbg_ack_reg <= src_reg == `SRC_DBG;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_fetch_ack = fetch_ack_reg;
    assign o_data_ack = data_ack_reg;
    assign o_dbg_ack = dbg_ack_reg;
    assign o_resp_err = err_reg;
    assign o_resp_rdata = rdata_reg;
    assign o_instr_req = instr_req_reg;
    assign o_data_port_req = data_port_req_reg;
    assign o_sys_req = sys_req_reg;
    assign o_ppb_psel = psel_reg;
    assign o_ppb_penable = penable_reg;
    assign o_mem_addr = addr_reg;
    assign o_mem_write = write_reg;
    assign o_mem_size = size_reg;
    assign o_mem_strb = strb_reg;
    assign o_mem_wdata = wdata_reg;
endmodule // ec_bus_matrix_router

`default_nettype wire

// ==== rtl/ec_bus_matrix_regs.vh ====
`ifndef EC_BUS_MATRIX_REGS_VH
`define EC_BUS_MATRIX_REGS_VH

// Access size codes
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2

// Target codes
`define TGT_INSTR 2'h0
`define TGT_DATA 2'h1
`define TGT_SYS 2'h2
`define TGT_PPB 2'h3

// Source codes
`define SRC_FETCH 2'h0
`define SRC_DATA 2'h1
`define SRC_DBG 2'h2
`define SRC_WBUF 2'h3

// Address map fields
`define CCM_HI 31:20
`define CCM_TAG 12'h000
`define PPB_HI 31:20
`define PPB_TAG 12'hE00
`define BB_HI 31:25
`define BB_SRAM_TAG 7'h11
`define BB_PERI_TAG 7'h21

// Byte strobe patterns
`define STRB_BYTE 4'h1
`define STRB_HALF 4'h3
`define STRB_WORD 4'hF

`endif

// ==== rtl/ec_write_buffer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ec_bus_matrix_regs.vh"

module ec_write_buffer
(
    input wire i_clk,
    input wire i_nrst,
    input wire i_push,
    input wire [31:0] i_addr,
    input wire [1:0] i_size,
    input wire [31:0] i_wdata,
    input wire i_pop,
    output wire o_full,
    output wire [31:0] o_addr,
    output wire [1:0] o_size,
    output wire [31:0] o_wdata
);
    reg full_reg;
    reg [31:0] addr_reg;
    reg [1:0] size_reg;
    reg [31:0] wdata_reg;

    // Single entry; caller never pushes while full
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            full_reg <= 1'b0; // RQ12
            addr_reg <= 32'h0000_0000;
            size_reg <= `SZ_WORD;
            wdata_reg <= 32'h0000_0000;
        end
        else if (i_push)
        begin
            full_reg <= 1'b1; // RQ9
            addr_reg <= i_addr;
            size_reg <= i_size;
            wdata_reg <= i_wdata;
        end
        else if (i_pop)
        begin
            full_reg <= 1'b0;
        end
    end

    assign o_full = full_reg;
    assign o_addr = addr_reg;
    assign o_size = size_reg;
    assign o_wdata = wdata_reg;
endmodule // ec_write_buffer

`default_nettype wire

// ==== tb/ec_bus_matrix_router_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ec_bus_matrix_regs.vh"

module ec_bus_matrix_router_chk
(
    input wire i_clk,
    input wire i_nrst,
    input wire i_data_write,
    input wire i_dbg_req,
    input wire o_fetch_ack,
    input wire o_data_ack,
    input wire o_dbg_ack,
    input wire [31:0] o_resp_rdata,
    input wire o_instr_req,
    input wire o_data_port_req,
    input wire o_sys_req,
    input wire o_ppb_psel,
    input wire o_ppb_penable,
    input wire [31:0] o_mem_addr,
    input wire o_mem_write,
    input wire [1:0] o_mem_size,
    input wire [3:0] o_mem_strb,
    input wire [31:0] o_mem_wdata
);
    // One clock domain, reset silences every check
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire busy = o_instr_req | o_data_port_req | o_sys_req | o_ppb_psel;

    // Decode of the shared address onto one target
    property p_one_tgt;
        $onehot0({o_instr_req, o_data_port_req, o_sys_req, o_ppb_psel});
    endproperty
    a_one_tgt: assert property (p_one_tgt) else $error("two targets at once");
    property p_ccm;
        o_instr_req | o_data_port_req |-> o_mem_addr[`CCM_HI] == `CCM_TAG && !(o_instr_req && o_mem_write);
    endproperty
    a_ccm: assert property (p_ccm) else $error("code port outside coupled memory");
    property p_sys;
        o_sys_req |-> o_mem_addr[`CCM_HI] != `CCM_TAG && o_mem_addr[`PPB_HI] != `PPB_TAG;
    endproperty
    a_sys: assert property (p_sys) else $error("system port on wrong region");
    property p_alias;
        o_mem_addr[`BB_HI] == `BB_SRAM_TAG || o_mem_addr[`BB_HI] == `BB_PERI_TAG |-> !(busy && !o_sys_req);
    endproperty
    a_alias: assert property (p_alias) else $error("alias left system port");
    // Lane placement is fixed little-endian
    property p_lanes;
        busy && o_mem_size == `SZ_BYTE |-> o_mem_strb == (4'h1 << o_mem_addr[1:0])
            && (!o_mem_write || o_mem_wdata == {4{o_mem_wdata[7:0]}});
    endproperty
    a_lanes: assert property (p_lanes) else $error("byte lane wrong");
    property p_ppb;
        o_ppb_psel |-> o_mem_size == `SZ_WORD && o_mem_strb == `STRB_WORD;
    endproperty
    a_ppb: assert property (p_ppb) else $error("narrow peripheral transfer");
    property p_apb;
        $rose(o_ppb_psel) |-> !o_ppb_penable ##1 o_ppb_psel && o_ppb_penable;
    endproperty
    a_apb: assert property (p_apb) else $error("peripheral phases wrong");
    // A second write may not be accepted while one is draining
    property p_wbuf;
        o_data_ack && i_data_write |-> !(busy && o_mem_write);
    endproperty
    a_wbuf: assert property (p_wbuf) else $error("write acked over pending write");
    property p_dbg;
        o_dbg_ack |-> i_dbg_req ##1 !o_dbg_ack;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug ack unasked or long");
    property p_rst;
        $rose(i_nrst) |-> !busy && !o_ppb_penable && !(o_fetch_ack | o_data_ack | o_dbg_ack)
            && o_mem_addr == 32'h0000_0000 && o_resp_rdata == 32'h0000_0000 && o_mem_size == `SZ_WORD
            && o_mem_strb == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
endmodule // ec_bus_matrix_router_chk

bind ec_bus_matrix_router ec_bus_matrix_router_chk u_chk (.i_clk, .i_nrst, .i_data_write, .i_dbg_req,
    .o_fetch_ack, .o_data_ack, .o_dbg_ack, .o_resp_rdata, .o_instr_req, .o_data_port_req, .o_sys_req,
    .o_ppb_psel, .o_ppb_penable, .o_mem_addr, .o_mem_write, .o_mem_size, .o_mem_strb, .o_mem_wdata);
`default_nettype wire

// ==== tb/ec_far_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ec_far_side_model
(
    input wire i_clk,
    input wire i_nrst,
    input wire [3:0] i_wait,
    input wire i_instr_req,
    input wire i_data_port_req,
    input wire i_sys_req,
    input wire i_ppb_psel,
    input wire i_ppb_penable,
    input wire [31:0] i_addr,
    output wire o_instr_ack,
    output wire o_data_port_ack,
    output wire o_sys_ack,
    output wire o_ppb_pready,
    output wire [31:0] o_instr_rdata,
    output wire [31:0] o_data_port_rdata,
    output wire [31:0] o_sys_rdata,
    output wire [31:0] o_ppb_prdata
);
    reg [3:0] cnt_reg;
    wire busy = i_instr_req | i_data_port_req | i_sys_req | (i_ppb_psel & i_ppb_penable);
    wire hit = busy && cnt_reg == i_wait;

    // Wait states on the free-running clock, one access at a time
    always @(posedge i_clk)
    begin
        cnt_reg <= (!i_nrst || !busy || hit) ? 4'h0 : cnt_reg + 4'h1;
    end

    // Only the port that asked is answered
    assign o_instr_ack = hit & i_instr_req;
    assign o_data_port_ack = hit & i_data_port_req;
    assign o_sys_ack = hit & i_sys_req;
    assign o_ppb_pready = hit & i_ppb_psel;
    // Data differs per port and flips when not answering, so stale reads show
    assign o_instr_rdata = ~i_addr ^ {32{~hit}};
    assign o_data_port_rdata = ~i_addr ^ 32'h1000_0000 ^ {32{~hit}};
    assign o_sys_rdata = ~i_addr ^ 32'h2000_0000 ^ {32{~hit}};
    assign o_ppb_prdata = ~i_addr ^ 32'h3000_0000 ^ {32{~hit}};
endmodule // ec_far_side_model
`default_nettype wire

// ==== tb/ec_bus_matrix_router_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ec_bus_matrix_regs.vh"

module ec_bus_matrix_router_tb_top;
    typedef struct packed {
        logic [1:0] m; logic w; logic [1:0] s; logic [31:0] ad; logic [31:0] d; logic [2:0] t; logic [3:0] strb;
    } row_t;
    reg i_clk = 1'b0;
    reg i_nrst = 1'b0;
    reg [2:0] req = 3'h0;
    reg wr = 1'b0;
    reg [1:0] sz = 2'h2;
    reg [31:0] a = 32'h0000_0000;
    reg [31:0] wd = 32'h0000_0000;
    reg [3:0] wait_n = 4'h0;
    reg [2:0] seen_tgt = 3'h4;
    reg [3:0] seen_strb = 4'h0;
    reg [31:0] seen_addr = 32'h0000_0000;
    reg [31:0] seen_wd = 32'h0000_0000;
    wire [2:0] ack;
    wire err, ireq, dreq, sreq, psel, pen, mwr, iack, dack, sack, prdy;
    wire [31:0] rdata, maddr, mwd, ird, drd, srd, prd;
    wire [1:0] msz;
    wire [3:0] mstrb;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int tacks = 0;
    // None of the targets is 3'h4: refused access
    row_t rows [14] = '{
        '{2'h0, 1'b0, `SZ_WORD, 32'h0000_1000, 32'h0000_0000, `TGT_INSTR, 4'hF},
        '{2'h1, 1'b0, `SZ_BYTE, 32'h0000_2001, 32'h0000_0000, `TGT_DATA, 4'h2},
        '{2'h1, 1'b0, `SZ_HALF, 32'h0000_2002, 32'h0000_0000, `TGT_DATA, 4'hC},
        '{2'h1, 1'b1, `SZ_WORD, 32'h2000_0004, 32'hCAFE_F00D, `TGT_SYS, 4'hF},
        '{2'h0, 1'b0, `SZ_WORD, 32'h2000_0010, 32'h0000_0000, `TGT_SYS, 4'hF},
        '{2'h1, 1'b0, `SZ_WORD, 32'h2200_0000, 32'h0000_0000, `TGT_SYS, 4'hF},
        '{2'h2, 1'b0, `SZ_WORD, 32'h4200_0004, 32'h0000_0000, `TGT_SYS, 4'hF},
        '{2'h2, 1'b0, `SZ_WORD, 32'h0000_3000, 32'h0000_0000, `TGT_DATA, 4'hF},
        '{2'h2, 1'b1, `SZ_WORD, 32'hE000_E010, 32'h8765_4321, `TGT_PPB, 4'hF},
        '{2'h1, 1'b0, `SZ_WORD, 32'hE000_E000, 32'h0000_0000, `TGT_PPB, 4'hF},
        '{2'h1, 1'b0, `SZ_HALF, 32'hE000_0004, 32'h0000_0000, 3'h4, 4'h0},
        '{2'h0, 1'b0, `SZ_WORD, 32'hE000_0000, 32'h0000_0000, 3'h4, 4'h0},
        '{2'h1, 1'b1, `SZ_BYTE, 32'h0000_0103, 32'h0000_005A, `TGT_DATA, 4'h8},
        '{2'h1, 1'b0, `SZ_WORD, 32'hFFFF_FFFC, 32'h0000_0000, `TGT_SYS, 4'hF}};

    ec_bus_matrix_router dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_fetch_req(req[0]), .i_fetch_addr(a),
        .i_data_req(req[1]), .i_data_write(wr), .i_data_size(sz), .i_data_addr(a), .i_data_wdata(wd),
        .i_dbg_req(req[2]), .i_dbg_write(wr), .i_dbg_size(sz), .i_dbg_addr(a), .i_dbg_wdata(wd),
        .o_fetch_ack(ack[0]), .o_data_ack(ack[1]), .o_dbg_ack(ack[2]), .o_resp_err(err), .o_resp_rdata(rdata),
        .o_instr_req(ireq), .i_instr_ack(iack), .i_instr_rdata(ird), .o_data_port_req(dreq),
        .i_data_port_ack(dack), .i_data_port_rdata(drd), .o_sys_req(sreq), .i_sys_ack(sack), .i_sys_rdata(srd),
        .o_ppb_psel(psel), .o_ppb_penable(pen), .i_ppb_pready(prdy), .i_ppb_prdata(prd), .o_mem_addr(maddr),
        .o_mem_write(mwr), .o_mem_size(msz), .o_mem_strb(mstrb), .o_mem_wdata(mwd));
    ec_far_side_model far (.i_clk(i_clk), .i_nrst(i_nrst), .i_wait(wait_n), .i_instr_req(ireq),
        .i_data_port_req(dreq), .i_sys_req(sreq), .i_ppb_psel(psel), .i_ppb_penable(pen), .i_addr(maddr),
        .o_instr_ack(iack), .o_data_port_ack(dack), .o_sys_ack(sack), .o_ppb_pready(prdy), .o_instr_rdata(ird),
        .o_data_port_rdata(drd), .o_sys_rdata(srd), .o_ppb_prdata(prd));

    always #25 i_clk = ~i_clk;

    // Record which target carried the access; watchdog on run length
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if ((iack | dack | sack | prdy) === 1'b1)
            tacks <= tacks + 1;
        if ((ireq | dreq | sreq | psel) === 1'b1)
        begin
            seen_tgt <= ireq ? `TGT_INSTR : dreq ? `TGT_DATA : sreq ? `TGT_SYS : `TGT_PPB;
            seen_strb <= mstrb;
            seen_addr <= maddr;
            seen_wd <= mwd;
        end
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input [31:0] got, input [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Hold the request until one falling edge after its ack is seen at a falling edge
    task automatic access(input [1:0] m, input w, input [1:0] s, input [31:0] ad, input [31:0] d, output int lat);
        @(negedge i_clk);
        wr = w;
        sz = s;
        a = ad;
        wd = d;
        seen_tgt = 3'h4;
        req[m] = 1'b1;
        lat = 0;
        // Ack is read between edges so the request still stands at the edge that samples it
        do
        begin
            @(negedge i_clk);
            lat++;
        end
        while (ack[m] !== 1'b1 && lat < 40);
        if (lat >= 40)
            miscompares++;
        @(negedge i_clk);
        req[m] = 1'b0;
    endtask

    // A buffered write drains after its ack, so always let one edge pass
    task automatic settle;
        int n;
        n = 0;
        @(posedge i_clk);
        #1;
        while ((ireq | dreq | sreq | psel) !== 1'b0 && n < 40)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 40)
            miscompares++;
    endtask

    function automatic [31:0] expect_rd(input [1:0] t, input [31:0] ad, input [1:0] s);
        reg [31:0] p;
        p = (~ad ^ {2'b00, t, 28'h000_0000}) >> {ad[1:0], 3'b000};
        expect_rd = s == `SZ_BYTE ? p & 32'h0000_00FF : s == `SZ_HALF ? p & 32'h0000_FFFF : p;
    endfunction

    function automatic [31:0] rep(input [31:0] d, input [1:0] s);
        rep = s == `SZ_BYTE ? {4{d[7:0]}} : s == `SZ_HALF ? {2{d[15:0]}} : d;
    endfunction

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        int lat;
        int t0;
        row_t r;
        repeat (5) @(negedge i_clk);
        i_nrst = 1'b1;
        // Table with prompt then slow far side
        for (int k = 0; k < 2; k++)
        begin
            wait_n = k ? 4'h3 : 4'h0;
            foreach (rows[i])
            begin
                r = rows[i];
                access(r.m, r.w, r.s, r.ad, r.d, lat);
                check({31'h0, err}, {31'h0, r.t == 3'h4});
                if (!r.w && r.t != 3'h4)
                    check(rdata, expect_rd(r.t[1:0], r.ad, r.s));
                settle();
                check({29'h0, seen_tgt}, {29'h0, r.t});
                if (r.t != 3'h4)
                begin
                    check({28'h0, seen_strb}, {28'h0, r.strb});
                    check(seen_addr, r.ad);
                    if (r.w)
                        check(seen_wd, rep(r.d, r.s));
                end
            end
        end
        // Back-to-back writes against a slow target
        wait_n = 4'h5;
        t0 = tacks;
        access(2'h1, 1'b1, `SZ_WORD, 32'h2000_0100, 32'h1234_5678, lat);
        check(lat, 32'h0000_0001);
        access(2'h1, 1'b1, `SZ_WORD, 32'h2000_0104, 32'h0BAD_BEEF, lat);
        check(tacks - t0, 32'h0000_0001);
        settle();
        // Reset in the middle of a slow read, then a clean access
        @(negedge i_clk);
        a = 32'h2000_0200;
        wr = 1'b0;
        req[1] = 1'b1;
        repeat (3) @(negedge i_clk);
        i_nrst = 1'b0;
        req[1] = 1'b0;
        @(negedge i_clk);
        i_nrst = 1'b1;
        check({31'h0, sreq}, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        access(2'h0, 1'b0, `SZ_WORD, 32'h0000_1000, 32'h0000_0000, lat);
        check(rdata, expect_rd(`TGT_INSTR, 32'h0000_1000, `SZ_WORD));
        complete_run();
    end
endmodule // ec_bus_matrix_router_tb_top
`default_nettype wire
